// *** logic/bpfc_pkg.sv ***
// Purpose: Constants, register map and types for the boost power-factor-correction controller
// Assumes: AHB-Lite slave with 32-bit data, one clock mclk at 50 MHz
// Notes: Q12 fixed point for gains and for the voltage loop output
// Overview of operation
// R1: One computation of both loops per tick; tick rate is PWM rate over divider plus one.
// R2: Current reference is voltage loop output times sampled AC voltage.
// R3: Reference minus feedback into current PI; add feedforward, limit, scale to duty.
// R4: Current PI clamped to zero..limit; integrator halts at the limit.
// R5: Setpoint passes a ramp with accel, decel and ramp shift; no step changes.
// R6: Ramped reference minus filtered bus feedback into voltage PI, clamped zero..limit.
// R7: Voltage integrator halts when output reaches upper limit.
// R8: Feedforward: AC over DC, two scales, clamp, subtracted from a constant.
// R9: Default feedforward gives at most three quarters of full modulation at zero crossing.
// R10: Full modulation equals the programmed PWM period value.
// R11: Duty forced to zero unless controller enable set; offset kept when cleared.
// R12: Shutdown asserts whenever bus voltage is below AC input voltage.
// R13: During shutdown PWM blanked and current PI disabled with state reset.
// R14: Readable blanking flag and run state output.
// R15: While run enable is zero, current offset is measured continuously.
// R16: When run enable becomes one, offset freezes and is subtracted from samples.
// R17: Software sets run enable only while no load current flows.
// R18: Over-current input drives PWM off at once, without waiting for computation.
// R19: After trip, switching resumes no earlier than next PWM cycle, after clear bit.
// R20: Clear bit held at one auto-clears each trip at the next PWM cycle.
// R21: Software writes the clear bit to one only briefly, then back to zero.
// R22: Bus setpoint should be at least five percent above peak AC voltage.
// R23: New duty latched into comparator only at next sync pulse at carrier minimum.
// R24: Switch on while latched duty is less than carrier count.
// R25: Shutdown stays asserted at least a configurable number of PWM cycles.
// R26: Within a tick: sample, voltage loop, current loop and feedforward, then present duty.
package bpfc_pkg;
	localparam int DataW = 16;
	localparam logic [7:0] AddrCtrl = 8'h00;
	localparam logic [7:0] AddrStatus = 8'h04;
	localparam logic [7:0] AddrPeriod = 8'h08;
	localparam logic [7:0] AddrDivider = 8'h0C;
	localparam logic [7:0] AddrSetpoint = 8'h10;
	localparam logic [7:0] AddrRamp = 8'h14;
	localparam logic [7:0] AddrVGain = 8'h18;
	localparam logic [7:0] AddrIGain = 8'h1C;
	localparam logic [7:0] AddrLimits = 8'h20;
	localparam logic [7:0] AddrFfScale = 8'h24;
	localparam logic [7:0] AddrFfLimit = 8'h28;
	localparam logic [7:0] AddrBlank = 8'h2C;
	localparam logic [7:0] AddrVout = 8'h30;
	localparam logic [7:0] AddrDuty = 8'h34;
	localparam logic [7:0] AddrOffset = 8'h38;
	localparam int CtrlRun = 0;
	localparam int CtrlCtl = 1;
	localparam int CtrlTripClr = 2;
	localparam int StBlank = 0;
	localparam int StRun = 1;
	localparam int StTrip = 2;
	localparam int QShift = 12;
	localparam int FiltShift = 3;
	localparam int OffShift = 4;
	localparam logic [15:0] PeriodRst = 16'h0341;
	localparam logic [7:0] DividerRst = 8'h00;
	localparam logic [15:0] SetpointRst = 16'h0000;
	localparam logic [15:0] AccelRst = 16'h0010;
	localparam logic [15:0] DecelRst = 16'h0010;
	localparam logic [3:0] RampShiftRst = 4'h4;
	localparam logic [15:0] GainRst = 16'h0100;
	localparam logic [15:0] LimVRst = 16'h1000;
	localparam logic [15:0] LimIRst = 16'h0341;
	localparam logic [15:0] FfScale1Rst = 16'h1000;
	localparam logic [15:0] FfScale2Rst = 16'h0341;
	localparam logic [15:0] FfLimitRst = 16'h0271;
	localparam logic [15:0] FfAddRst = 16'h0271;
	localparam logic [7:0] BlankCyclesRst = 8'h04;
	typedef enum logic [4:0] {
		SIdle = 5'b00001,
		SSample = 5'b00010,
		SVolt = 5'b00100,
		SCurr = 5'b01000,
		SPresent = 5'b10000
	} bpfc_state_t;
endpackage

// *** logic/bpfc_controller.sv ***
// Purpose: Boost PFC control loops, PWM, blanking and over-current trip with AHB-Lite registers
// Assumes: ADC samples are unsigned and already synchronous; trip pin is asynchronous
// Notes: Zero wait-state slave; unmapped addresses read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
module bpfc_controller #(
	parameter int DataW = bpfc_pkg::DataW
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [DataW-1:0] acVoltage,
	input wire logic [DataW-1:0] busVoltage,
	input wire logic [DataW-1:0] boostCurrent,
	input wire logic overcurrentTrip,
	output logic gateDrive,
	output logic blanking_flag,
	output logic run_state_output
);
	localparam int W = DataW;
	localparam int WX = 2 * DataW + 2;

	// Bus slave
	logic wrPend_reg;
	logic [7:0] wrAddr_reg;
	logic [31:0] rdata_reg;
	wire accessOk = hsel && hready && htrans[1];
	wire [7:0] aPhase = haddr[7:0];
	wire doWrite = wrPend_reg;

	logic [2:0] ctrl_reg;
	logic [15:0] pwm_period_value_reg;
	logic [7:0] control_tick_divider_reg;
	logic [15:0] setpoint_reg, accel_reg, decel_reg;
	logic [3:0] ramp_rate_shift_reg;
	logic [15:0] voltage_prop_gain_reg, voltage_integ_gain_reg;
	logic [15:0] current_prop_gain_reg, current_integ_gain_reg;
	logic [15:0] limV_reg, limI_reg;
	logic [15:0] feedforward_scale_one_reg, feedforward_scale_two_reg;
	logic [15:0] feedforward_clamp_reg, feedforward_constant_reg;
	logic [7:0] min_blank_cycles_reg;

	wire run_enable_bit = ctrl_reg[bpfc_pkg::CtrlRun];
	wire controller_enable_bit = ctrl_reg[bpfc_pkg::CtrlCtl];
	wire overcurrent_trip_clear = ctrl_reg[bpfc_pkg::CtrlTripClr];

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wrPend_reg <= 1'b0;
			wrAddr_reg <= 8'h00;
		end else begin
			wrPend_reg <= accessOk && hwrite;
			wrAddr_reg <= aPhase;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg <= 3'h0;
			pwm_period_value_reg <= bpfc_pkg::PeriodRst;
			control_tick_divider_reg <= bpfc_pkg::DividerRst;
			setpoint_reg <= bpfc_pkg::SetpointRst;
			accel_reg <= bpfc_pkg::AccelRst;
			decel_reg <= bpfc_pkg::DecelRst;
			ramp_rate_shift_reg <= bpfc_pkg::RampShiftRst;
			voltage_prop_gain_reg <= bpfc_pkg::GainRst;
			voltage_integ_gain_reg <= bpfc_pkg::GainRst;
			current_prop_gain_reg <= bpfc_pkg::GainRst;
			current_integ_gain_reg <= bpfc_pkg::GainRst;
			limV_reg <= bpfc_pkg::LimVRst;
			limI_reg <= bpfc_pkg::LimIRst;
			feedforward_scale_one_reg <= bpfc_pkg::FfScale1Rst;
			feedforward_scale_two_reg <= bpfc_pkg::FfScale2Rst;
			feedforward_clamp_reg <= bpfc_pkg::FfLimitRst;
			feedforward_constant_reg <= bpfc_pkg::FfAddRst;
			min_blank_cycles_reg <= bpfc_pkg::BlankCyclesRst;
		end else if (doWrite) begin
			case (wrAddr_reg)
				bpfc_pkg::AddrCtrl: ctrl_reg <= hwdata[2:0];
				bpfc_pkg::AddrPeriod: pwm_period_value_reg <= hwdata[15:0];
				bpfc_pkg::AddrDivider: control_tick_divider_reg <= hwdata[7:0];
				bpfc_pkg::AddrSetpoint: setpoint_reg <= hwdata[15:0];
				bpfc_pkg::AddrRamp: begin
					accel_reg <= {4'h0, hwdata[11:0]};
					decel_reg <= {4'h0, hwdata[27:16]};
					ramp_rate_shift_reg <= hwdata[31:28];
				end
				bpfc_pkg::AddrVGain: begin
					voltage_prop_gain_reg <= hwdata[15:0];
					voltage_integ_gain_reg <= hwdata[31:16];
				end
				bpfc_pkg::AddrIGain: begin
					current_prop_gain_reg <= hwdata[15:0];
					current_integ_gain_reg <= hwdata[31:16];
				end
				bpfc_pkg::AddrLimits: begin
					limV_reg <= hwdata[15:0];
					limI_reg <= hwdata[31:16];
				end
				bpfc_pkg::AddrFfScale: begin
					feedforward_scale_one_reg <= hwdata[15:0];
					feedforward_scale_two_reg <= hwdata[31:16];
				end
				bpfc_pkg::AddrFfLimit: begin
					feedforward_clamp_reg <= hwdata[15:0];
					feedforward_constant_reg <= hwdata[31:16];
				end
				bpfc_pkg::AddrBlank: min_blank_cycles_reg <= hwdata[7:0];
				default: ctrl_reg <= ctrl_reg;
			endcase
		end
	end

	// Trip pin synchroniser: only stages two and three are looked at
	logic [2:0] tripSync_reg;
	logic tripLevel_reg;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tripSync_reg <= 3'b000;
			tripLevel_reg <= 1'b0;
		end else begin
			tripSync_reg <= {tripSync_reg[1:0], overcurrentTrip};
			if (tripSync_reg[1] == tripSync_reg[2])
				tripLevel_reg <= tripSync_reg[2];
		end
	end

	// PWM carrier, up-down
	// One PWM cycle is 2 * period + 1 clocks; sync marks the carrier minimum
	logic [15:0] carrier_reg;
	logic carrierUp_reg;
	logic [15:0] dutyLatched_reg;
	wire syncPulse = !carrierUp_reg && (carrier_reg == 16'h0000);
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			carrier_reg <= 16'h0000;
			carrierUp_reg <= 1'b0;
		end else if (carrierUp_reg) begin
			carrier_reg <= carrier_reg + 16'h0001;
			if (carrier_reg + 16'h0001 >= pwm_period_value_reg)
				carrierUp_reg <= 1'b0;
		end else if (carrier_reg == 16'h0000) begin
			carrierUp_reg <= 1'b1;
		end else begin
			carrier_reg <= carrier_reg - 16'h0001;
		end
	end

	// Control tick divider
	logic [7:0] tickCnt_reg;
	wire tick = syncPulse && (tickCnt_reg == control_tick_divider_reg); // R1
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			tickCnt_reg <= 8'h00;
		else if (syncPulse)
			tickCnt_reg <= (tickCnt_reg >= control_tick_divider_reg) ? 8'h00 : tickCnt_reg + 8'h01;
	end

	// Blanking compares bus against AC and holds a minimum number of PWM cycles
	// Count reloads while the bus is low, so the minimum runs from the end of the event
	logic shutdown_reg;
	logic [7:0] blankCnt_reg;
	wire busLow = busVoltage < acVoltage; // R12
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			shutdown_reg <= 1'b0;
			blankCnt_reg <= 8'h00;
		end else if (busLow) begin
			shutdown_reg <= 1'b1; // R12
			blankCnt_reg <= min_blank_cycles_reg; // R25
		end else if (syncPulse && blankCnt_reg != 8'h00) begin
			blankCnt_reg <= blankCnt_reg - 8'h01; // R25
		end else if (blankCnt_reg == 8'h00) begin
			shutdown_reg <= 1'b0;
		end
	end

	// Trip latch; a new trip wins over a clear in the same cycle
	logic tripped_reg;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			tripped_reg <= 1'b0;
		else if (tripLevel_reg)
			tripped_reg <= 1'b1;
		else if (syncPulse && overcurrent_trip_clear)
			tripped_reg <= 1'b0; // R19 R20
	end

	// Current offset tracking and freeze
	// Slow on purpose: a sixteenth of the error per tick keeps switching ripple out
	logic [W-1:0] offset_reg;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			offset_reg <= '0;
		else if (!run_enable_bit && tick)
			offset_reg <= offset_reg + W'((32'(boostCurrent) - 32'(offset_reg)) >>> bpfc_pkg::OffShift); // R15 R16
	end

	// Sequenced loop computation
	bpfc_pkg::bpfc_state_t state_reg, state_next;
	logic signed [WX-1:0] acS_reg, busF_reg, iFb_reg, rampRef_reg;
	logic signed [WX-1:0] vInteg_reg, vOut_reg, iInteg_reg, iOut_reg, ff_reg;
	logic [15:0] dutyCmd_reg;

	always_comb begin
		case (state_reg)
			bpfc_pkg::SIdle: state_next = tick ? bpfc_pkg::SSample : bpfc_pkg::SIdle;
			bpfc_pkg::SSample: state_next = bpfc_pkg::SVolt;
			bpfc_pkg::SVolt: state_next = bpfc_pkg::SCurr;
			bpfc_pkg::SCurr: state_next = bpfc_pkg::SPresent;
			default: state_next = bpfc_pkg::SIdle;
		endcase
	end

	wire signed [WX-1:0] stepUp = WX'(accel_reg >> ramp_rate_shift_reg);
	wire signed [WX-1:0] stepDn = WX'(decel_reg >> ramp_rate_shift_reg);
	wire signed [WX-1:0] setS = WX'(setpoint_reg);
	// Ramp never steps past the setpoint, so it lands on it exactly
	wire signed [WX-1:0] rampUp = rampRef_reg + stepUp;
	wire signed [WX-1:0] rampDn = rampRef_reg - stepDn;
	// Signed step so a falling bus pulls the filter down instead of wrapping
	wire signed [WX-1:0] busS = $signed(WX'(busVoltage));
	wire signed [WX-1:0] busStep = (busS - busF_reg) >>> bpfc_pkg::FiltShift;
	wire signed [WX-1:0] iSample = $signed(WX'(boostCurrent)) - $signed(WX'(offset_reg)); // R16
	wire signed [WX-1:0] vErr = rampRef_reg - busF_reg; // R6
	wire signed [WX-1:0] vPi = vInteg_reg + WX'((vErr * $signed({1'b0, voltage_prop_gain_reg})) >>> bpfc_pkg::QShift);
	wire signed [WX-1:0] vInc = WX'((vErr * $signed({1'b0, voltage_integ_gain_reg})) >>> bpfc_pkg::QShift);
	wire signed [WX-1:0] limVS = WX'(limV_reg);
	wire signed [WX-1:0] limIS = WX'(limI_reg);
	wire signed [WX-1:0] iRef = WX'((vOut_reg * acS_reg) >>> bpfc_pkg::QShift); // R2
	wire signed [WX-1:0] iErr = iRef - iFb_reg; // R3
	wire signed [WX-1:0] iPi = iInteg_reg + WX'((iErr * $signed({1'b0, current_prop_gain_reg})) >>> bpfc_pkg::QShift);
	wire signed [WX-1:0] iInc = WX'((iErr * $signed({1'b0, current_integ_gain_reg})) >>> bpfc_pkg::QShift);
	// Integrators stop only when pushing further into the clamp, so they can still recover
	wire vHalt = (vPi >= limVS && vInc > 0) || (vPi < 0 && vInc < 0); // R7
	wire iHalt = (iPi >= limIS && iInc > 0) || (iPi < 0 && iInc < 0); // R4
	wire signed [WX-1:0] ratio = (busF_reg > 0) ? WX'((acS_reg <<< bpfc_pkg::QShift) / busF_reg) : '0; // R8
	wire signed [WX-1:0] ffScaled = WX'((((ratio * $signed({1'b0, feedforward_scale_one_reg})) >>> bpfc_pkg::QShift)
		* $signed({1'b0, feedforward_scale_two_reg})) >>> bpfc_pkg::QShift); // R8
	// Limit and constant taken as signed so a negative term is not read as huge
	wire signed [WX-1:0] ffLimS = WX'(feedforward_clamp_reg);
	wire signed [WX-1:0] ffAddS = WX'(feedforward_constant_reg);
	wire signed [WX-1:0] ffClamp = (ffScaled > ffLimS) ? ffLimS : ffScaled;
	wire signed [WX-1:0] ffNew = ffAddS - ffClamp; // R8 R9
	wire signed [WX-1:0] sumCmd = iOut_reg + ff_reg; // R3
	wire signed [WX-1:0] periodS = WX'(pwm_period_value_reg);
	wire signed [WX-1:0] sumLim = (sumCmd < 0) ? '0 : ((sumCmd > periodS) ? periodS : sumCmd); // R10
	wire [15:0] dutyNew = controller_enable_bit ? 16'(sumLim) : 16'h0000; // R11

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= bpfc_pkg::SIdle;
			acS_reg <= '0;
			busF_reg <= '0;
			iFb_reg <= '0;
			rampRef_reg <= '0;
			vInteg_reg <= '0;
			vOut_reg <= '0;
			iInteg_reg <= '0;
			iOut_reg <= '0;
			ff_reg <= '0;
			dutyCmd_reg <= 16'h0000;
		end else begin
			state_reg <= state_next;
			case (state_reg)
				bpfc_pkg::SSample: begin // R26
					acS_reg <= WX'(acVoltage);
					busF_reg <= busF_reg + busStep;
					iFb_reg <= iSample; // R16
					if (rampUp < setS)
						rampRef_reg <= rampUp; // R5
					else if (rampDn > setS)
						rampRef_reg <= rampDn; // R5
					else
						rampRef_reg <= setS;
				end
				bpfc_pkg::SVolt: begin
					if (vPi >= limVS)
						vOut_reg <= limVS; // R6 R7
					else if (vPi < 0)
						vOut_reg <= '0; // R6
					else
						vOut_reg <= vPi;
					if (!vHalt)
						vInteg_reg <= vInteg_reg + vInc; // R7
				end
				bpfc_pkg::SCurr: begin
					ff_reg <= ffNew; // R8
					if (shutdown_reg || !controller_enable_bit) begin
						iInteg_reg <= '0; // R13
						iOut_reg <= '0;
					end else begin
						if (iPi >= limIS)
							iOut_reg <= limIS; // R4
						else if (iPi < 0)
							iOut_reg <= '0; // R4
						else
							iOut_reg <= iPi;
						if (!iHalt)
							iInteg_reg <= iInteg_reg + iInc; // R4
					end
				end
				bpfc_pkg::SPresent: dutyCmd_reg <= dutyNew; // R26 R11
				default: dutyCmd_reg <= dutyCmd_reg;
			endcase
		end
	end

	// Comparator, blanking and trip gate the switch
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dutyLatched_reg <= 16'h0000;
			gateDrive <= 1'b0;
			blanking_flag <= 1'b0;
			run_state_output <= 1'b0;
		end else begin
			if (syncPulse)
				dutyLatched_reg <= dutyCmd_reg; // R23
			// Filtered trip level (stages two and three agreeing) used so the pin kills the gate without waiting for the latch
			gateDrive <= (dutyLatched_reg < carrier_reg) && !shutdown_reg && !tripped_reg
				&& !tripLevel_reg && controller_enable_bit; // R24 R13 R18
			blanking_flag <= shutdown_reg; // R14
			run_state_output <= run_enable_bit && controller_enable_bit && !tripped_reg; // R14
		end
	end

	// Read mux
	wire [31:0] statusWord = {29'h0, tripped_reg, run_state_output, blanking_flag};
	logic [31:0] rdMux;
	always_comb begin
		case (aPhase)
			bpfc_pkg::AddrCtrl: rdMux = {29'h0, ctrl_reg};
			bpfc_pkg::AddrStatus: rdMux = statusWord;
			bpfc_pkg::AddrPeriod: rdMux = {16'h0, pwm_period_value_reg};
			bpfc_pkg::AddrDivider: rdMux = {24'h0, control_tick_divider_reg};
			bpfc_pkg::AddrSetpoint: rdMux = {16'h0, setpoint_reg};
			bpfc_pkg::AddrRamp: rdMux = {ramp_rate_shift_reg, decel_reg[11:0], 4'h0, accel_reg[11:0]};
			bpfc_pkg::AddrVGain: rdMux = {voltage_integ_gain_reg, voltage_prop_gain_reg};
			bpfc_pkg::AddrIGain: rdMux = {current_integ_gain_reg, current_prop_gain_reg};
			bpfc_pkg::AddrLimits: rdMux = {limI_reg, limV_reg};
			bpfc_pkg::AddrFfScale: rdMux = {feedforward_scale_two_reg, feedforward_scale_one_reg};
			bpfc_pkg::AddrFfLimit: rdMux = {feedforward_constant_reg, feedforward_clamp_reg};
			bpfc_pkg::AddrBlank: rdMux = {24'h0, min_blank_cycles_reg};
			bpfc_pkg::AddrVout: rdMux = 32'(vOut_reg);
			bpfc_pkg::AddrDuty: rdMux = {16'h0, dutyCmd_reg};
			bpfc_pkg::AddrOffset: rdMux = 32'(offset_reg);
			default: rdMux = 32'h00000000;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			rdata_reg <= 32'h00000000;
		else if (accessOk && !hwrite)
			rdata_reg <= rdMux;
	end

	assign hrdata = rdata_reg;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
endmodule
`default_nettype wire

// *** verif/bpfc_boost_plant.sv ***
// Purpose: Behavioural boost stage: line and bus sense levels, inductor current sense
// Assumes: sense values are registered on mclk like the converter outputs they stand for
// Notes: Current ripple is a crude ramp; only its sign relative to the offset matters here
`timescale 1ns/1ps
`default_nettype none
module bpfc_boost_plant (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic gateDrive,
	input wire logic [15:0] acLevel,
	input wire logic [15:0] busLevel,
	input wire logic [15:0] currentBias,
	output logic [15:0] acVoltage,
	output logic [15:0] busVoltage,
	output logic [15:0] boostCurrent
);
	logic [15:0] ripple;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ripple <= 16'h0000;
			acVoltage <= 16'h0000;
			busVoltage <= 16'h0000;
			boostCurrent <= 16'h0000;
		end else begin
			acVoltage <= acLevel;
			busVoltage <= busLevel;
			if (gateDrive && ripple < 16'h00FF) begin
				ripple <= ripple + 16'h0001;
			end else if (!gateDrive && ripple != 16'h0000) begin
				ripple <= ripple - 16'h0001;
			end
			// No load current outside the switch ripple, so only the sense bias is seen at start
			boostCurrent <= currentBias + ripple;
		end
	end
endmodule
`default_nettype wire

// *** verif/bpfc_controller_properties.sv ***
// Purpose: Concurrent checks on the PFC controller ports
// Assumes: one mclk domain, rstn asynchronous active low
// Notes: Trip and blanking windows leave room for the input synchroniser and output register
`timescale 1ns/1ps
`default_nettype none
module bpfc_controller_properties #(
	parameter int DataW = 16
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [DataW-1:0] acVoltage,
	input wire logic [DataW-1:0] busVoltage,
	input wire logic overcurrentTrip,
	input wire logic gateDrive,
	input wire logic blanking_flag,
	input wire logic run_state_output
);
	logic rdAddr;
	logic busOk;
	assign rdAddr = hsel && hready && htrans[1] && !hwrite;
	assign busOk = busVoltage >= acVoltage;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);

	bus_answer_a: assert property (hreadyout && !hresp)
		else $error("bus answer is not zero-wait OKAY");
	reset_quiet_a: assert property ($rose(rstn) |-> !gateDrive && !blanking_flag && !run_state_output)
		else $error("outputs active right after reset");
	rdata_hold_a: assert property (!$past(rdAddr) |-> $stable(hrdata))
		else $error("read data moved without a read");
	trip_kill_a: assert property (overcurrentTrip [*6] |-> !gateDrive)
		else $error("gate still on during over-current");
	shut_set_a: assert property ((busVoltage < acVoltage) [*4] |-> blanking_flag)
		else $error("no blanking with bus below line");
	blank_gate_a: assert property (blanking_flag && $past(blanking_flag) |-> !gateDrive)
		else $error("gate on while blanked");
	blank_min_a: assert property ($rose(blanking_flag) |=> blanking_flag [*8])
		else $error("blanking released too soon");
	blank_rel_a: assert property ($fell(blanking_flag) |-> $past(busOk, 2))
		else $error("blanking released with bus below line");

	cover property (overcurrentTrip [*6]);
	cover property ($rose(blanking_flag));
	cover property ($fell(blanking_flag));
	cover property (rdAddr);
endmodule

bind bpfc_controller bpfc_controller_properties #(.DataW(DataW)) u_props (.mclk(mclk), .rstn(rstn),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .acVoltage(acVoltage), .busVoltage(busVoltage), .overcurrentTrip(overcurrentTrip),
	.gateDrive(gateDrive), .blanking_flag(blanking_flag), .run_state_output(run_state_output));
`default_nettype wire

// *** verif/tb.sv ***
// Purpose: Register-level test of the PFC controller against a behavioural boost stage
// Assumes: zero-wait AHB-Lite slave, hready taken from hreadyout
// Notes: Period is cut to 64 after the default-period checks so offset settling stays short
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic mclk, rstn, hsel, hwrite, hready, hreadyout, hresp, overcurrentTrip, gateDrive;
	logic blanking_flag, run_state_output;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd, prev;
	logic [15:0] acVoltage, busVoltage, boostCurrent, acLevel, busLevel, currentBias;
	int error_cnt, checked, hi, n;
	time t0;
	assign hready = hreadyout;

	bpfc_controller u_dut (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .acVoltage(acVoltage), .busVoltage(busVoltage),
		.boostCurrent(boostCurrent), .overcurrentTrip(overcurrentTrip), .gateDrive(gateDrive),
		.blanking_flag(blanking_flag), .run_state_output(run_state_output));
	bpfc_boost_plant u_plant (.mclk(mclk), .rstn(rstn), .gateDrive(gateDrive), .acLevel(acLevel),
		.busLevel(busLevel), .currentBias(currentBias), .acVoltage(acVoltage), .busVoltage(busVoltage),
		.boostCurrent(boostCurrent));

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task checkTrue(input logic c);
		check({31'h0000_0000, c}, 32'h0000_0001);
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge mclk);
		while (hready !== 1'b1) @(posedge mclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge mclk);
		while (hready !== 1'b1) @(posedge mclk);
		rd = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0000_0000);
		check(rd, exp);
	endtask
	task cyc(input int k);
		repeat (k) @(posedge mclk);
	endtask
	// Gate is sampled 1 ns after the edge so its register has settled
	task gateHigh(input int k);
		hi = 0;
		repeat (k) begin
			@(posedge mclk);
			#1;
			if (gateDrive === 1'b1) hi++;
		end
	endtask
	task results;
		$display("Errors %0d, checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		repeat (90000) @(posedge mclk);
		error_cnt++;
		results();
	end
	initial begin
		rstn = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000; htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010;
		hwdata = 32'h0000_0000; overcurrentTrip = 1'b0; acLevel = 16'h0000; busLevel = 16'h03E8;
		currentBias = 16'h0028; error_cnt = 0; checked = 0;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		rdc(bpfc_pkg::AddrCtrl, 32'h0000_0000);
		rdc(bpfc_pkg::AddrPeriod, {16'h0000, bpfc_pkg::PeriodRst});
		rdc(bpfc_pkg::AddrDivider, {24'h00_0000, bpfc_pkg::DividerRst});
		rdc(bpfc_pkg::AddrRamp, {bpfc_pkg::RampShiftRst, bpfc_pkg::DecelRst[11:0], 4'h0,
			bpfc_pkg::AccelRst[11:0]});
		rdc(bpfc_pkg::AddrLimits, {bpfc_pkg::LimIRst, bpfc_pkg::LimVRst});
		rdc(bpfc_pkg::AddrFfScale, {bpfc_pkg::FfScale2Rst, bpfc_pkg::FfScale1Rst});
		rdc(bpfc_pkg::AddrFfLimit, {bpfc_pkg::FfAddRst, bpfc_pkg::FfLimitRst});
		rdc(bpfc_pkg::AddrBlank, {24'h00_0000, bpfc_pkg::BlankCyclesRst});
		wr(8'h3C, 32'hFFFF_FFFF);
		rdc(8'h3C, 32'h0000_0000);
		wr(bpfc_pkg::AddrStatus, 32'h0000_0007);
		rdc(bpfc_pkg::AddrStatus, 32'h0000_0000);
		wr(bpfc_pkg::AddrSetpoint, 32'h0000_03E8);
		rdc(bpfc_pkg::AddrSetpoint, 32'h0000_03E8);
		// Run without controller enable: modulation must stay at zero
		wr(bpfc_pkg::AddrCtrl, 32'h0000_0001);
		cyc(3400);
		rdc(bpfc_pkg::AddrDuty, 32'h0000_0000);
		gateHigh(1700);
		check(hi, 0);
		check({31'h0000_0000, run_state_output}, 32'h0000_0000);
		// Zero crossing with no current demand: duty is the feedforward constant alone
		wr(bpfc_pkg::AddrCtrl, 32'h0000_0003);
		cyc(8400);
		rdc(bpfc_pkg::AddrDuty, {16'h0000, bpfc_pkg::FfAddRst});
		checkTrue(run_state_output);
		acLevel <= 16'h0064;
		cyc(5000);
		xfer(1'b0, bpfc_pkg::AddrDuty, 32'h0000_0000);
		checkTrue(rd < {16'h0000, bpfc_pkg::FfAddRst} && rd > 32'h0000_0000);
		// Shorter PWM cycle, feedforward fixed at half modulation
		wr(bpfc_pkg::AddrCtrl, 32'h0000_0000);
		wr(bpfc_pkg::AddrPeriod, 32'h0000_0040);
		wr(bpfc_pkg::AddrFfLimit, 32'h0020_0000);
		cyc(12800);
		xfer(1'b0, bpfc_pkg::AddrOffset, 32'h0000_0000);
		checkTrue(rd >= 32'h0000_0018 && rd <= 32'h0000_0028);
		prev = rd;
		wr(bpfc_pkg::AddrCtrl, 32'h0000_0003);
		currentBias <= 16'h005A;
		cyc(4000);
		rdc(bpfc_pkg::AddrOffset, prev);
		wr(bpfc_pkg::AddrCtrl, 32'h0000_0001);
		cyc(300);
		rdc(bpfc_pkg::AddrOffset, prev);
		wr(bpfc_pkg::AddrCtrl, 32'h0000_0000);
		cyc(4000);
		xfer(1'b0, bpfc_pkg::AddrOffset, 32'h0000_0000);
		checkTrue(rd > prev);
		wr(bpfc_pkg::AddrCtrl, 32'h0000_0003);
		cyc(1000);
		rdc(bpfc_pkg::AddrDuty, 32'h0000_0020);
		gateHigh(256);
		checkTrue(hi > 0);
		// Single trip: stays off until the clear bit has been set across a sync
		overcurrentTrip <= 1'b1;
		cyc(10);
		overcurrentTrip <= 1'b0;
		xfer(1'b0, bpfc_pkg::AddrStatus, 32'h0000_0000);
		check(rd[bpfc_pkg::StTrip], 1'b1);
		check(rd[bpfc_pkg::StRun], 1'b0);
		gateHigh(384);
		check(hi, 0);
		wr(bpfc_pkg::AddrCtrl, 32'h0000_0007);
		cyc(130);
		wr(bpfc_pkg::AddrCtrl, 32'h0000_0003);
		gateHigh(384);
		checkTrue(hi > 0);
		// Clear bit held: each trip clears itself at the next cycle
		wr(bpfc_pkg::AddrCtrl, 32'h0000_0007);
		overcurrentTrip <= 1'b1;
		cyc(10);
		overcurrentTrip <= 1'b0;
		cyc(10);
		gateHigh(384);
		checkTrue(hi > 0);
		wr(bpfc_pkg::AddrCtrl, 32'h0000_0003);
		// Bus below line: blank, then hold for the minimum count of PWM cycles
		busLevel <= 16'h0032;
		@(posedge blanking_flag);
		t0 = $time;
		cyc(20);
		xfer(1'b0, bpfc_pkg::AddrStatus, 32'h0000_0000);
		check(rd[bpfc_pkg::StBlank], 1'b1);
		gateHigh(128);
		check(hi, 0);
		busLevel <= 16'h03E8;
		n = 0;
		while (blanking_flag === 1'b1 && n < 5000) begin
			@(posedge mclk);
			n++;
		end
		checkTrue($time - t0 >= 4 * 128 * 20 && n < 5000);
		results();
	end
endmodule
`default_nettype wire
